// file: sad_decoder.sv
// system address decoder: routes host memory and io cycles to dram, hub link port or graphics port, and terminates cycles above 4 GB
//
// Design decisions made here: strobed register access and the address map.
`include "sad_map.svh"
module sad_decoder (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic req_valid,
    input wire logic [35:0] req_addr,
    input wire logic req_write,
    input wire logic req_io,
    input wire logic req_smm,
    input wire sad_pkg::sad_source_e req_src,
    input wire logic [63:0] req_wdata,
    output logic route_valid,
    output sad_pkg::sad_target_e route_target,
    output logic route_write,
    output logic [35:0] route_addr,
    output logic [63:0] route_wdata,
    output logic term_rdata_valid,
    output logic [63:0] term_rdata
);
    import sad_pkg::*;

    logic [25:0] attr_reg, attr_next;
    logic [3:0] ctrl_reg, ctrl_next;
    logic [11:0] top_of_main_memory_reg, top_of_main_memory_next;
    logic [31:0] rdata_reg, rdata_next;
    sad_target_e last_reg, last_next;
    logic valid_reg, valid_next;
    sad_target_e target_reg, target_next;
    logic write_reg, write_next;
    logic [35:0] addr_reg, addr_next;
    logic [63:0] wdata_reg, wdata_next;
    logic tval_reg, tval_next;
    sad_target_e decoded;

    // segment number 0..12 for c0000..fffff
    function automatic logic [3:0] seg_index(input logic [35:0] a);
        logic [5:0] s;
        s = a[19:14] - `SAD_SEG_BASE;
        if (a >= `SAD_SYS_LO)
            return `SAD_SEG_SYS;
        return s[3:0];
    endfunction

    function automatic logic mono_io(input logic [35:0] a);
        logic [15:0] p;
        p = a[15:0];
        return a[35:16] == 20'h00000 &&
            (p == `SAD_IO_MONO_4 || p == `SAD_IO_MONO_5 || p == `SAD_IO_MONO_8 ||
             p == `SAD_IO_MONO_9 || p == `SAD_IO_MONO_A || p == `SAD_IO_MONO_F);
    endfunction

    // legacy steering: graphics port claims vga when its enable bit is set, unless mono adapter sits on the hub side
    function automatic sad_target_e steer(input logic mono, input logic vga_en, input logic mono_here);
        if (!vga_en)
            return SAD_HUB;
        if (mono && mono_here)
            return SAD_HUB;
        return SAD_GFX;
    endfunction

    always_comb begin
        logic [3:0] si;
        logic seg_rd_en;
        logic seg_wr_en;
        si = seg_index(req_addr);
        seg_rd_en = attr_reg[{si, 1'b0}];
        seg_wr_en = attr_reg[{si, 1'b1}];
        decoded = SAD_HUB;
        if (req_io) begin
            if (mono_io(req_addr))
                decoded = steer(1'b1, ctrl_reg[`SAD_CTRL_VGA], ctrl_reg[`SAD_CTRL_MONO]);
        end else if (req_addr >= `SAD_FOUR_GB) begin
            decoded = SAD_TERM;
        end else if (req_addr < `SAD_DOS_END) begin
            decoded = SAD_DRAM;
        end else if (req_addr < `SAD_VGA_END) begin
            // compatible smram only for cpu cycles in smm; others see the video buffer
            if (ctrl_reg[`SAD_CTRL_SMRAM] && req_smm && req_src == SAD_SRC_CPU)
                decoded = SAD_DRAM;
            else
                decoded = steer(req_addr >= `SAD_MONO_LO && req_addr < `SAD_MONO_END,
                                ctrl_reg[`SAD_CTRL_VGA], ctrl_reg[`SAD_CTRL_MONO]);
        end else if (req_addr < `SAD_ONE_MB) begin
            // disabled segments fall to the hub, the dram behind them stays unreachable
            if (req_write ? seg_wr_en : seg_rd_en)
                decoded = SAD_DRAM;
        end else if (req_addr < {4'h0, top_of_main_memory_reg, 20'h00000}) begin
            // no relocation of the hole: that dram is simply lost
            if (!(ctrl_reg[`SAD_CTRL_HOLE] && req_addr >= `SAD_HOLE_LO && req_addr < `SAD_HOLE_END))
                decoded = SAD_DRAM;
        end else begin
            // top of memory to 4 GB is pci or graphics window space, never dram
            decoded = SAD_HUB;
        end
    end

    always_comb begin
        attr_next = attr_reg;
        ctrl_next = ctrl_reg;
        top_of_main_memory_next = top_of_main_memory_reg;
        rdata_next = 32'h0000_0000;
        if (reg_wr) begin
            case (reg_addr)
                `SAD_OFS_ATTR: attr_next = reg_wdata[25:0];
                `SAD_OFS_CTRL: ctrl_next = reg_wdata[3:0];
                `SAD_OFS_TOP_OF_MAIN_MEMORY: top_of_main_memory_next = reg_wdata[11:0];
                default: ;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                `SAD_OFS_ATTR: rdata_next = {6'h00, attr_reg};
                `SAD_OFS_CTRL: rdata_next = {28'h000_0000, ctrl_reg};
                `SAD_OFS_TOP_OF_MAIN_MEMORY: rdata_next = {20'h0_0000, top_of_main_memory_reg};
                `SAD_OFS_STAT: rdata_next = {28'h000_0000, last_reg};
                default: rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            attr_reg <= `SAD_ATTR_RST;
            ctrl_reg <= `SAD_CTRL_RST;
            top_of_main_memory_reg <= `SAD_TOP_OF_MAIN_MEMORY_RST;
            rdata_reg <= 32'h0000_0000;
        end else begin
            attr_reg <= attr_next;
            ctrl_reg <= ctrl_next;
            top_of_main_memory_reg <= top_of_main_memory_next;
            rdata_reg <= rdata_next;
        end
    end

    always_comb begin
        valid_next = req_valid;
        target_next = req_valid ? decoded : target_reg;
        write_next = req_valid ? req_write : write_reg;
        addr_next = req_valid ? req_addr : addr_reg;
        wdata_next = 64'h0000_0000_0000_0000;
        tval_next = 1'b0;
        last_next = req_valid ? decoded : last_reg;
        if (req_valid && decoded != SAD_TERM && req_write)
            wdata_next = req_wdata;
        if (req_valid && decoded == SAD_TERM && !req_write)
            tval_next = 1'b1;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            valid_reg <= 1'b0;
            target_reg <= SAD_HUB;
            write_reg <= 1'b0;
            addr_reg <= 36'h0_0000_0000;
            wdata_reg <= 64'h0000_0000_0000_0000;
            tval_reg <= 1'b0;
            last_reg <= SAD_HUB;
        end else begin
            valid_reg <= valid_next;
            target_reg <= target_next;
            write_reg <= write_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
            tval_reg <= tval_next;
            last_reg <= last_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign route_valid = valid_reg;
    assign route_target = target_reg;
    assign route_write = write_reg;
    assign route_addr = addr_reg;
    assign route_wdata = wdata_reg;
    assign term_rdata_valid = tval_reg;
    // terminated reads always return zero; the bus is held at zero at all times
    assign term_rdata = 64'h0000_0000_0000_0000;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    logic mem_req;
    assign mem_req = req_valid && !req_io;

    // range helpers for the checks, written from the address map rather than the decode chain
    logic vga_hit;
    logic mono_hit;
    logic smram_hit;
    logic in_seg;
    logic in_hole;
    logic in_main;
    assign vga_hit = mem_req && req_addr >= `SAD_DOS_END && req_addr < `SAD_VGA_END;
    assign mono_hit = vga_hit && req_addr >= `SAD_MONO_LO && req_addr < `SAD_MONO_END;
    assign smram_hit = ctrl_reg[`SAD_CTRL_SMRAM] && req_smm && req_src == SAD_SRC_CPU;
    assign in_seg = mem_req && req_addr >= `SAD_VGA_END && req_addr < `SAD_ONE_MB;
    assign in_hole = ctrl_reg[`SAD_CTRL_HOLE] && req_addr >= `SAD_HOLE_LO && req_addr < `SAD_HOLE_END;
    assign in_main = mem_req && req_addr >= `SAD_ONE_MB && req_addr < {4'h0, top_of_main_memory_reg, 20'h00000};

    above_4g_a: assert property (mem_req && req_addr >= `SAD_FOUR_GB |=>
        route_valid && route_target == SAD_TERM) else $error("access above 4 GB not terminated");
    term_data_a: assert property (route_valid && route_target == SAD_TERM |->
        route_wdata == 64'h0 && term_rdata_valid == !route_write) else $error("terminated data leaked");
    dos_dram_a: assert property (mem_req && req_addr < `SAD_DOS_END |=>
        route_target == SAD_DRAM) else $error("low memory not sent to dram");
    seg_attr_a: assert property (mem_req && req_addr >= `SAD_VGA_END && req_addr < `SAD_ONE_MB
        && (req_write ? attr_reg[{seg_index(req_addr), 1'b1}] : attr_reg[{seg_index(req_addr), 1'b0}])
        |=> route_target == SAD_DRAM) else $error("enabled segment not sent to dram");
    seg_off_a: assert property (mem_req && req_addr >= `SAD_VGA_END && req_addr < `SAD_ONE_MB
        && attr_reg[{seg_index(req_addr), 1'b0}] == 1'b0 && !req_write
        |=> route_target == SAD_HUB) else $error("disabled segment read not sent to hub");
    sys_reset_a: assert property ($rose(reset_n) |-> attr_reg[25:24] == 2'b00)
        else $error("system bios segment not disabled after reset");
    smm_dram_a: assert property (mem_req && req_addr >= `SAD_DOS_END && req_addr < `SAD_VGA_END
        && ctrl_reg[`SAD_CTRL_SMRAM] && req_smm && req_src == SAD_SRC_CPU
        |=> route_target == SAD_DRAM) else $error("smm cpu cycle missed dram");
    smm_other_a: assert property (mem_req && req_addr >= `SAD_DOS_END && req_addr < `SAD_VGA_END
        && req_src != SAD_SRC_CPU |=> route_target != SAD_DRAM) else $error("non-cpu cycle reached smram");
    mono_io_a: assert property (req_valid && req_io && mono_io(req_addr) && !ctrl_reg[`SAD_CTRL_VGA]
        |=> route_target == SAD_HUB) else $error("mono io port misrouted");
    hole_hub_a: assert property (mem_req && ctrl_reg[`SAD_CTRL_HOLE] && req_addr >= `SAD_HOLE_LO
        && req_addr < `SAD_HOLE_END |=> route_target == SAD_HUB) else $error("hole cycle reached dram");
    above_tom_a: assert property (mem_req && req_addr >= {4'h0, top_of_main_memory_reg, 20'h00000} && req_addr >= `SAD_ONE_MB
        && req_addr < `SAD_FOUR_GB |=> route_target == SAD_HUB) else $error("cycle above top reached dram");

    // legacy video steering, checked for each setting of the two steering bits except both set on the mono io ports
    vga_off_a: assert property (vga_hit && !smram_hit && !ctrl_reg[`SAD_CTRL_VGA]
        |=> route_target == SAD_HUB)
        else $error("vga cycle not sent to hub");
    vga_on_a: assert property (vga_hit && !mono_hit && !smram_hit && ctrl_reg[`SAD_CTRL_VGA]
        |=> route_target == SAD_GFX)
        else $error("vga cycle not sent to graphics port");
    mono_hub_a: assert property (mono_hit && !smram_hit && ctrl_reg[`SAD_CTRL_VGA] && ctrl_reg[`SAD_CTRL_MONO]
        |=> route_target == SAD_HUB)
        else $error("mono range not sent to hub");
    mono_gfx_a: assert property (mono_hit && !smram_hit && ctrl_reg[`SAD_CTRL_VGA] && !ctrl_reg[`SAD_CTRL_MONO]
        |=> route_target == SAD_GFX)
        else $error("mono range not sent to graphics port");
    mono_port_a: assert property (req_valid && req_io && mono_io(req_addr) && ctrl_reg[`SAD_CTRL_VGA]
        && !ctrl_reg[`SAD_CTRL_MONO] |=> route_target == SAD_GFX)
        else $error("mono io port not sent to graphics port");
    io_other_a: assert property (req_valid && req_io && !mono_io(req_addr)
        |=> route_target == SAD_HUB)
        else $error("plain io port not sent to hub");

    // a disabled write must never reach the shadow dram; main memory goes to dram and only cycles above 4 GB terminate
    seg_wr_off_a: assert property (in_seg && req_write && !attr_reg[{seg_index(req_addr), 1'b1}]
        |=> route_target == SAD_HUB)
        else $error("disabled segment write reached dram");
    main_dram_a: assert property (in_main && !in_hole
        |=> route_target == SAD_DRAM)
        else $error("main memory cycle not sent to dram");
    term_only_a: assert property (route_valid && route_target == SAD_TERM
        |-> route_addr >= `SAD_FOUR_GB)
        else $error("cycle below 4 GB terminated locally");

    term_read_c: cover property (mem_req && !req_write && req_addr >= `SAD_FOUR_GB ##1 term_rdata_valid);
    shadow_c: cover property (reg_wr && reg_addr == `SAD_OFS_ATTR ##2 mem_req && req_addr >= `SAD_SYS_LO
        && req_addr < `SAD_ONE_MB ##1 route_target == SAD_DRAM);
    vga_gfx_c: cover property (mem_req ##1 route_target == SAD_GFX);
    hole_c: cover property (mem_req && ctrl_reg[`SAD_CTRL_HOLE] ##1 route_target == SAD_HUB);
    mono_port_c: cover property (req_valid && req_io && mono_io(req_addr) ##1 route_target == SAD_GFX);
endmodule

// file: sad_host_model.sv
// host bus master model issuing one memory or io cycle at a time
module sad_host_model (
    input wire logic clk,
    output logic req_valid,
    output logic [35:0] req_addr,
    output logic req_write,
    output logic req_io,
    output logic req_smm,
    output sad_pkg::sad_source_e req_src,
    output logic [63:0] req_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    import sad_pkg::*;
    initial begin
        req_valid = 1'b0;
        req_addr = 36'h0;
        req_write = 1'b0;
        req_io = 1'b0;
        req_smm = 1'b0;
        req_src = SAD_SRC_CPU;
        req_wdata = 64'h0;
    end
    // decoder never stalls, so a cycle is held for exactly one edge
    task automatic send(input logic [35:0] a, input logic w, io, smm, input sad_source_e s, input logic [63:0] d);
        @(posedge clk);
        req_valid <= 1'b1;
        req_addr <= a;
        req_write <= w;
        req_io <= io;
        req_smm <= smm;
        req_src <= s;
        req_wdata <= d;
        @(posedge clk);
        req_valid <= 1'b0;
        // released address and data show junk, not the last value; the other request lines keep theirs
        req_addr <= ~a;
        req_wdata <= ~d;
    endtask
endmodule

// file: sad_map.svh
// address boundaries, register offsets and field positions of the system address decoder
`ifndef SAD_MAP_SVH
`define SAD_MAP_SVH
`define SAD_DOS_END 36'h0_000a_0000
`define SAD_MONO_LO 36'h0_000b_0000
`define SAD_MONO_END 36'h0_000b_8000
`define SAD_VGA_END 36'h0_000c_0000
`define SAD_SYS_LO 36'h0_000f_0000
`define SAD_ONE_MB 36'h0_0010_0000
`define SAD_HOLE_LO 36'h0_00f0_0000
`define SAD_HOLE_END 36'h0_0100_0000
`define SAD_FOUR_GB 36'h1_0000_0000
`define SAD_SEG_BASE 6'h30
`define SAD_SEG_SYS 4'hc
`define SAD_SEG_COUNT 13
`define SAD_IO_MONO_4 16'h03b4
`define SAD_IO_MONO_5 16'h03b5
`define SAD_IO_MONO_8 16'h03b8
`define SAD_IO_MONO_9 16'h03b9
`define SAD_IO_MONO_A 16'h03ba
`define SAD_IO_MONO_F 16'h03bf
`define SAD_OFS_ATTR 4'h0
`define SAD_OFS_CTRL 4'h4
`define SAD_OFS_TOP_OF_MAIN_MEMORY 4'h8
`define SAD_OFS_STAT 4'hc
`define SAD_CTRL_HOLE 0
`define SAD_CTRL_VGA 1
`define SAD_CTRL_MONO 2
`define SAD_CTRL_SMRAM 3
`define SAD_ATTR_RST 26'h000_0000
`define SAD_CTRL_RST 4'h0
`define SAD_TOP_OF_MAIN_MEMORY_RST 12'h040
`endif

// file: sad_pkg.sv
// types shared by the system address decoder
package sad_pkg;
    typedef enum logic [3:0] {
        SAD_DRAM = 4'h1,
        SAD_HUB = 4'h2,
        SAD_GFX = 4'h4,
        SAD_TERM = 4'h8
    } sad_target_e;
    typedef enum logic [1:0] {
        SAD_SRC_CPU = 2'h0,
        SAD_SRC_GFX = 2'h1,
        SAD_SRC_HUB = 2'h2
    } sad_source_e;
endpackage

// file: system_address_decoder_test.sv
// self-checking bench for the system address decoder
module system_address_decoder_test;
    timeunit 1ns;
    timeprecision 1ns;
    import sad_pkg::*;
    logic clk, reset_n, reg_wr, reg_rd, req_valid, req_write, req_io, req_smm;
    logic route_valid, route_write, term_rdata_valid;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [35:0] req_addr, route_addr;
    logic [63:0] req_wdata, route_wdata, term_rdata;
    sad_source_e req_src;
    sad_target_e route_target;
    int n_errors = 0;
    int checks_done = 0;
    sad_decoder dut_u (.*);
    sad_host_model host_u (.*);
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(64'(reg_rdata), 64'(exp));
    endtask
    task automatic req(input logic [35:0] a, input logic w, io, smm, input sad_source_e s, input sad_target_e t);
        logic [63:0] d;
        d = 64'h0123_4567_89ab_cdef ^ 64'(a);
        host_u.send(a, w, io, smm, s, d);
        #1;
        chk(64'(route_valid), 64'h1);
        chk(64'(route_target), 64'(t));
        chk(64'(route_addr), 64'(a));
        chk(64'(route_write), 64'(w));
        chk(route_wdata, (w && t != SAD_TERM) ? d : 64'h0);
        chk(64'(term_rdata_valid), 64'(!w && t == SAD_TERM));
        chk(term_rdata, 64'h0);
    endtask
    task automatic m(input logic [35:0] a, input logic w, input sad_target_e t);
        req(a, w, 1'b0, 1'b0, SAD_SRC_CPU, t);
    endtask
    task automatic t_reset();
        rd(4'h0, 32'h0);
        rd(4'h8, 32'h40);
        wr(4'h2, 32'hffff_ffff);
        rd(4'h2, 32'h0);
        m(36'hf_8000, 1'b0, SAD_HUB);
        m(36'hf_8000, 1'b1, SAD_HUB);
        rd(4'hc, 32'h2);
        wr(4'hc, 32'h1);
        rd(4'hc, 32'h2);
        rd(4'h4, 32'h0);
    endtask
    task automatic t_low();
        m(36'h1_0000_0000, 1'b0, SAD_TERM);
        m(36'hf_ffff_fff8, 1'b1, SAD_TERM);
        wr(4'h0, 32'h03ff_ffff);
        wr(4'h4, 32'hf);
        m(36'h0, 1'b0, SAD_DRAM);
        m(36'h9_fff8, 1'b1, SAD_DRAM);
        m(36'h1_0000_0040, 1'b1, SAD_TERM);
        wr(4'h0, 32'h0);
    endtask
    task automatic t_seg();
        logic [35:0] a;
        for (int n = 0; n < 13; n++) begin
            a = 36'hc_2000 + 36'(n) * 36'h4000;
            wr(4'h0, 32'h1 << (2 * n));
            m(a, 1'b0, SAD_DRAM);
            m(a, 1'b1, SAD_HUB);
            m(a + 36'h4000, 1'b0, n == 12 ? SAD_DRAM : SAD_HUB);
            wr(4'h0, 32'h2 << (2 * n));
            m(a, 1'b1, SAD_DRAM);
            m(a, 1'b0, SAD_HUB);
        end
        wr(4'h0, 32'h0);
    endtask
    task automatic t_vga();
        logic [15:0] ports [6] = '{16'h3b4, 16'h3b5, 16'h3b8, 16'h3b9, 16'h3ba, 16'h3bf};
        sad_target_e tm;
        for (int c = 0; c < 4; c++) begin
            wr(4'h4, 32'(c << 1));
            tm = c == 1 ? SAD_GFX : SAD_HUB;
            m(36'ha_4000, 1'b0, c[0] ? SAD_GFX : SAD_HUB);
            m(36'hb_0000, 1'b1, tm);
            m(36'hb_8000, 1'b0, c[0] ? SAD_GFX : SAD_HUB);
            foreach (ports[i]) begin
                req(36'(ports[i]), 1'b0, 1'b1, 1'b0, SAD_SRC_CPU, tm);
            end
            req(36'h3b6, 1'b1, 1'b1, 1'b0, SAD_SRC_CPU, SAD_HUB);
        end
    endtask
    task automatic t_smm();
        wr(4'h4, 32'h8);
        req(36'ha_0000, 1'b0, 1'b0, 1'b1, SAD_SRC_CPU, SAD_DRAM);
        req(36'hb_fff8, 1'b1, 1'b0, 1'b1, SAD_SRC_CPU, SAD_DRAM);
        req(36'ha_0000, 1'b0, 1'b0, 1'b1, SAD_SRC_GFX, SAD_HUB);
        req(36'ha_0000, 1'b1, 1'b0, 1'b1, SAD_SRC_HUB, SAD_HUB);
        wr(4'h4, 32'ha);
        req(36'ha_0000, 1'b0, 1'b0, 1'b0, SAD_SRC_CPU, SAD_GFX);
        req(36'ha_0000, 1'b0, 1'b0, 1'b1, SAD_SRC_GFX, SAD_GFX);
    endtask
    task automatic t_hole();
        wr(4'h4, 32'h0);
        wr(4'h8, 32'h40);
        m(36'h20_0000, 1'b1, SAD_DRAM);
        m(36'hf0_0000, 1'b0, SAD_DRAM);
        wr(4'h4, 32'h1);
        m(36'hf0_0000, 1'b0, SAD_HUB);
        m(36'hff_fff8, 1'b1, SAD_HUB);
        m(36'h100_0000, 1'b0, SAD_DRAM);
        m(36'h3ff_fff8, 1'b0, SAD_DRAM);
        m(36'h400_0000, 1'b0, SAD_HUB);
        m(36'hfec0_0000, 1'b1, SAD_HUB);
    endtask
    task automatic close_out();
        if (n_errors == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // whole run is well under two thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        close_out();
    end
    initial begin
        reset_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        t_reset();
        t_low();
        t_seg();
        t_vga();
        t_smm();
        t_hole();
        close_out();
    end
endmodule
